/* File: common/vemtc_pkg.sv */
// Constants, types and helpers of the mode/sync-timing control block.
// Assumes one 40 MHz mclk domain; line figures are nominal PAL/NTSC.
package vemtc_pkg;
  typedef logic [3:0] vemtc_luma_t;
  localparam logic [7:0] OUT_MODE_ADDR = 8'h04;
  localparam logic [7:0] SYNC_TIM_ADDR = 8'h07;
  localparam logic [7:0] OUT_MODE_RST  = 8'h00;
  localparam logic [7:0] SYNC_TIM_RST  = 8'h00;
  // output_and_power_mode fields
  localparam int OM_FMT_BIT   = 0;
  localparam int OM_COMP_BIT  = 1;
  localparam int OM_SYNC_BIT  = 2;
  localparam int OM_LONG_BIT  = 3;
  localparam int OM_SETUP_BIT = 4;
  localparam int OM_FILT_BIT  = 5;
  localparam int OM_SLEEP_BIT = 6;
  // sync_timing_control fields
  localparam int ST_MST_BIT   = 0;
  localparam int ST_TMODE_LSB = 1;
  localparam int ST_BLANK_BIT = 3;
  localparam int ST_LUMA_LSB  = 4;
  localparam int ST_PIX_BIT   = 6;
  localparam int ST_TCR_BIT   = 7;
  // Timing
  localparam int MCLK_MHZ       = 40;
  localparam int LUMA_STEP_NS   = 74;
  localparam int NTSC_LINE_NS   = 63556;
  localparam int PAL_LINE_NS    = 64000;
  localparam int NTSC_HBLANK_NS = 10900;
  localparam int PAL_HBLANK_NS  = 12000;
  localparam vemtc_luma_t LUMA_STEP_CYC =
    4'((LUMA_STEP_NS * MCLK_MHZ + 999) / 1000);
  localparam logic [11:0] NTSC_LINE_CYC = 12'(NTSC_LINE_NS * MCLK_MHZ / 1000);
  localparam logic [11:0] PAL_LINE_CYC  = 12'(PAL_LINE_NS * MCLK_MHZ / 1000);
  localparam logic [11:0] NTSC_HALF_CYC = 12'(NTSC_LINE_NS * MCLK_MHZ / 2000);
  localparam logic [11:0] PAL_HALF_CYC  = 12'(PAL_LINE_NS * MCLK_MHZ / 2000);
  localparam logic [11:0] NTSC_HBL_CYC  =
    12'((NTSC_HBLANK_NS * MCLK_MHZ + 999) / 1000);
  localparam logic [11:0] PAL_HBL_CYC   =
    12'((PAL_HBLANK_NS * MCLK_MHZ + 999) / 1000);
  localparam logic [9:0] NTSC_FRAME_LINES = 10'h20d;
  localparam logic [9:0] PAL_FRAME_LINES  = 10'h271;
  localparam logic [9:0] NTSC_VBL_LINES   = 10'h014;
  localparam logic [9:0] PAL_VBL_LINES    = 10'h016;
  // Vertical sync widths in half-lines
  localparam logic [3:0] NTSC_LONG_VS_HL = 4'h6;
  localparam logic [3:0] PAL_LONG_VS_HL  = 4'h5;
  localparam logic [3:0] SHORT_VS_HL     = 4'h2;
  // Serial port slave address, value arbitrary
  localparam logic [6:0] PORT_DEV_ADDR = 7'h2a;

  // Level of a pin after its three-stage chain: moves only on agreement
  function automatic logic sync_settle(input logic [2:0] s, input logic f);
    return (s[1] == s[2]) ? s[2] : f;
  endfunction
endpackage

/* File: common/vemtc_reg_if.sv */
// Register access path between the serial port and the register bank.
// Assumes both ends on mclk; wr is a one-cycle strobe.
`timescale 1ns/1ps
interface vemtc_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic [7:0] rdata;
  modport port (output addr, output wdata, output wr, input rdata);
  modport bank (input addr, input wdata, input wr, output rdata);
endinterface

/* File: design/vemtc_i2c_slave.sv */
// Two-wire serial register port: sub-address write, auto-increment.
// Assumes SCL/SDA asynchronous and well below mclk/8 in rate.
`timescale 1ns/1ps
module vemtc_i2c_slave (
  input  wire logic  mclk,
  input  wire logic  rst_b,
  input  wire logic  ce,
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       sda_drive,
  output logic       sda_oe,
  vemtc_reg_if.port  rif
);
  import vemtc_pkg::*;

  typedef enum logic [6:0] {
    P_IDLE  = 7'h01,
    P_ADDR  = 7'h02,
    P_AACK  = 7'h04,
    P_WRITE = 7'h08,
    P_WACK  = 7'h10,
    P_READ  = 7'h20,
    P_RACK  = 7'h40
  } vemtc_pst_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_f;
    logic       sda_f;
    vemtc_pst_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic       rw;
    logic       sub;
    logic       bump;
    logic       mack;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       oe;
  } vemtc_port_t;

  localparam vemtc_port_t PRST = '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1,
    sda_f: 1'b1, st: P_IDLE, default: '0};

  vemtc_port_t q, d;
  logic scl_n, sda_n, rise, fall, start, stop;

  assign scl_n = sync_settle(q.scl_s, q.scl_f);
  assign sda_n = sync_settle(q.sda_s, q.sda_f);
  assign rise  = scl_n & ~q.scl_f;
  assign fall  = ~scl_n & q.scl_f;
  assign start = q.scl_f & scl_n & q.sda_f & ~sda_n;
  assign stop  = q.scl_f & scl_n & ~q.sda_f & sda_n;

  always_comb begin
    d       = q;
    d.scl_s = {q.scl_s[1:0], scl};
    d.sda_s = {q.sda_s[1:0], sda};
    d.scl_f = scl_n;
    d.sda_f = sda_n;
    d.wr    = 1'b0;
    if (start) begin
      d.st   = P_ADDR;
      d.bits = 4'h0;
      d.oe   = 1'b0;
    end else if (stop) begin
      d.st = P_IDLE;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        P_ADDR, P_WRITE: begin
          if (rise) begin
            d.bits = q.bits + 4'h1;
            d.sh   = {q.sh[6:0], sda_n};
          end else if (fall && q.bits == 4'h8) begin
            d.bits = 4'h0;
            if (q.st == P_ADDR) begin
              d.st  = (q.sh[7:1] == PORT_DEV_ADDR) ? P_AACK : P_IDLE;
              d.oe  = (q.sh[7:1] == PORT_DEV_ADDR);
              d.rw  = q.sh[0];
              d.sub = 1'b1;
            end else begin
              d.st   = P_WACK;
              d.oe   = 1'b1;
              d.bump = ~q.sub;
              d.sub  = 1'b0;
              if (q.sub) begin
                d.addr = q.sh;
              end else begin
                d.wr    = 1'b1;
                d.wdata = q.sh;
              end
            end
          end
        end
        P_AACK: if (fall) begin
          d.st = q.rw ? P_READ : P_WRITE;
          d.sh = rif.rdata;
          d.oe = q.rw & ~rif.rdata[7];
        end
        P_WACK: if (fall) begin
          d.st = P_WRITE;
          d.oe = 1'b0;
          if (q.bump) d.addr = q.addr + 8'h01;
        end
        P_READ: begin
          if (rise) begin
            d.bits = q.bits + 4'h1;
          end else if (fall && q.bits == 4'h8) begin
            d.st   = P_RACK;
            d.oe   = 1'b0;
            d.bits = 4'h0;
            d.addr = q.addr + 8'h01;
          end else if (fall) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
          end
        end
        P_RACK: begin
          if (rise) d.mack = ~sda_n;
          else if (fall) begin
            d.st = q.mack ? P_READ : P_IDLE;
            d.sh = rif.rdata;
            d.oe = q.mack & ~rif.rdata[7];
          end
        end
        P_IDLE: d.oe = 1'b0;
        default: d.st = P_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= PRST;
    end else if (ce) begin
      q <= d;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_drive = 1'b0;
  assign sda_oe    = q.oe;
  assign rif.addr  = q.addr;
  assign rif.wdata = q.wdata;
  assign rif.wr    = q.wr;
endmodule

/* File: design/vemtc_top.sv */
// Output/power mode and sync timing control registers with their
// serial port and a line/frame counter for master and slave sync.
// Assumes mclk 40 MHz; pal_select comes from logic on mclk.
`timescale 1ns/1ps
module vemtc_top (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  input  wire logic          scl,
  input  wire logic          sda,
  output logic               sda_drive,
  output logic               sda_oe,
  input  wire logic          pal_select,
  input  wire logic          vsync_in_b,
  input  wire logic          blank_in_b,
  output logic               composite_video,
  output logic               component_ypbpr,
  output logic               sync_on_colour,
  output logic               pedestal_enable,
  output logic               blank_filter_active,
  output logic               sleep_active,
  output logic               timing_master,
  output logic [1:0]         timing_mode_field,
  output logic               blank_input_used,
  output vemtc_pkg::vemtc_luma_t luma_delay_cycles,
  output logic               pixel_port_format_bit,
  output logic               timing_counter_reset,
  output logic               vsync_out_b,
  output logic               blank_out_b
);
  import vemtc_pkg::*;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  tim;
    logic        armed;
    logic        tcr;
    logic [2:0]  vs_s;
    logic        vs_f;
    logic [2:0]  bl_s;
    logic        bl_f;
    logic [11:0] cyc;
    logic [9:0]  line;
    logic        comp;
    logic        ypbpr;
    logic        synccol;
    logic        ped;
    logic        filt;
    logic        sleep;
    logic        mst;
    logic [1:0]  tmode;
    logic        bl_use;
    vemtc_luma_t luma;
    logic        pix;
    logic        vs_out_b;
    logic        blank_b;
  } vemtc_top_t;

  localparam vemtc_top_t TRST = '{mode: OUT_MODE_RST, tim: SYNC_TIM_RST,
    vs_s: 3'h7, vs_f: 1'b1, bl_s: 3'h7, bl_f: 1'b1, comp: 1'b1,
    vs_out_b: 1'b1, default: '0};

  function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                  input logic [7:0] off);
    return w & (a == off);
  endfunction

  vemtc_top_t  q, d;
  vemtc_reg_if rif ();
  logic        vs_n, bl_n, vs_fall, om_wr, st_wr, tc_fire, slave_sync;
  logic        line_end, in_vs, blank_now;
  logic [11:0] line_cyc, half_cyc, hbl_cyc;
  logic [9:0]  frame_lines, vbl_lines;
  logic [3:0]  vs_len;
  logic [10:0] half_idx;

  // Port runs whatever the sleep state, so sleep never blocks access
  vemtc_i2c_slave u_port (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ce        (ce),
    .scl       (scl),
    .sda       (sda),
    .sda_drive (sda_drive),
    .sda_oe    (sda_oe),
    .rif       (rif)
  );

  assign rif.rdata = (rif.addr == OUT_MODE_ADDR) ? q.mode :
                     (rif.addr == SYNC_TIM_ADDR) ? q.tim : 8'h00;

  assign vs_n    = sync_settle(q.vs_s, q.vs_f);
  assign bl_n    = sync_settle(q.bl_s, q.bl_f);
  assign vs_fall = q.vs_f & ~vs_n;
  assign om_wr   = wr_hit(rif.wr, rif.addr, OUT_MODE_ADDR);
  assign st_wr   = wr_hit(rif.wr, rif.addr, SYNC_TIM_ADDR);
  assign tc_fire = st_wr & q.armed & ~rif.wdata[ST_TCR_BIT];
  // A slave re-phases only on the falling edge, so a held-low
  // vsync of 2.5 or 3 lines is taken once
  assign slave_sync = vs_fall & ~q.tim[ST_MST_BIT];

  assign line_cyc    = pal_select ? PAL_LINE_CYC : NTSC_LINE_CYC;
  assign half_cyc    = pal_select ? PAL_HALF_CYC : NTSC_HALF_CYC;
  assign hbl_cyc     = pal_select ? PAL_HBL_CYC : NTSC_HBL_CYC;
  assign frame_lines = pal_select ? PAL_FRAME_LINES : NTSC_FRAME_LINES;
  assign vbl_lines   = pal_select ? PAL_VBL_LINES : NTSC_VBL_LINES;
  assign vs_len = !q.mode[OM_LONG_BIT] ? SHORT_VS_HL :
                  pal_select ? PAL_LONG_VS_HL : NTSC_LONG_VS_HL;
  assign half_idx = {q.line, 1'b0} + {10'h000, q.cyc >= half_cyc};
  assign in_vs    = half_idx < {7'h00, vs_len};
  assign line_end = q.cyc >= line_cyc - 12'h001;
  // External blank only counts in slave mode with its enable set
  assign blank_now = q.cyc < hbl_cyc || q.line < vbl_lines ||
                     (q.tim[ST_BLANK_BIT] & ~q.tim[ST_MST_BIT] &
                      ~q.bl_f);

  always_comb begin
    d      = q;
    d.vs_s = {q.vs_s[1:0], vsync_in_b};
    d.bl_s = {q.bl_s[1:0], blank_in_b};
    d.vs_f = vs_n;
    d.bl_f = bl_n;
    d.tcr  = tc_fire;
    if (om_wr) d.mode = rif.wdata;
    if (st_wr) begin
      d.tim   = rif.wdata;
      d.armed = rif.wdata[ST_TCR_BIT] & (q.armed | ~q.tim[ST_TCR_BIT]);
    end
    if (tc_fire || slave_sync) begin
      d.cyc  = 12'h000;
      d.line = 10'h000;
    end else if (!q.mode[OM_SLEEP_BIT]) begin
      if (line_end) begin
        d.cyc  = 12'h000;
        d.line = (q.line >= frame_lines - 10'h001) ? 10'h000 :
                 q.line + 10'h001;
      end else begin
        d.cyc = q.cyc + 12'h001;
      end
    end
    d.comp     = ~q.mode[OM_FMT_BIT];
    d.ypbpr    = q.mode[OM_FMT_BIT] & q.mode[OM_COMP_BIT];
    d.synccol  = q.mode[OM_FMT_BIT] & q.mode[OM_SYNC_BIT];
    d.ped      = q.mode[OM_SETUP_BIT] & ~pal_select;
    d.blank_b  = ~blank_now;
    d.filt     = q.mode[OM_FILT_BIT] & blank_now;
    d.sleep    = q.mode[OM_SLEEP_BIT];
    d.mst      = q.tim[ST_MST_BIT];
    d.tmode    = q.tim[ST_TMODE_LSB+:2];
    d.bl_use   = q.tim[ST_BLANK_BIT] & ~q.tim[ST_MST_BIT];
    d.luma     = {2'b00, q.tim[ST_LUMA_LSB+:2]} * LUMA_STEP_CYC;
    d.pix      = q.tim[ST_PIX_BIT];
    d.vs_out_b = ~(q.tim[ST_MST_BIT] & ~q.mode[OM_SLEEP_BIT] & in_vs);
  end

  // Async reset clears the sleep bit too, so reset always wakes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= TRST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign composite_video       = q.comp;
  assign component_ypbpr       = q.ypbpr;
  assign sync_on_colour        = q.synccol;
  assign pedestal_enable       = q.ped;
  assign blank_filter_active   = q.filt;
  assign sleep_active          = q.sleep;
  assign timing_master         = q.mst;
  assign timing_mode_field     = q.tmode;
  assign blank_input_used      = q.bl_use;
  assign luma_delay_cycles     = q.luma;
  assign pixel_port_format_bit = q.pix;
  assign timing_counter_reset  = q.tcr;
  assign vsync_out_b           = q.vs_out_b;
  assign blank_out_b           = q.blank_b;

  // Helper: length of each master vsync pulse, and whether it ran clean
  // Clean means it began at line 0 cycle 0 and no write cut into it
  logic [13:0] vs_cnt;
  logic        vs_clean;
  logic [13:0] vs_exp;
  assign vs_exp = 14'(vs_len) * 14'(half_cyc);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vs_cnt   <= 14'h0000;
      vs_clean <= 1'b0;
    end else if (ce) begin
      vs_cnt   <= q.vs_out_b ? 14'h0000 : vs_cnt + 14'h0001;
      vs_clean <= q.vs_out_b ? (q.cyc == 12'h000 && q.line == 10'h000) :
                  (vs_clean & ~rif.wr);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence sleep_wr_s(bit v);
    om_wr && rif.wdata[OM_SLEEP_BIT] == v && ce ##1 ce;
  endsequence

  fmt_select_a: assert property (
    ce |=> composite_video == !$past(q.mode[OM_FMT_BIT]))
    else $error("composite output does not follow format bit");
  ypbpr_select_a: assert property (
    ce && q.mode[OM_FMT_BIT] |=> component_ypbpr == $past(q.mode[OM_COMP_BIT]))
    else $error("YPbPr select wrong");
  sync_colour_a: assert property (
    ce && q.mode[OM_FMT_BIT] |=> sync_on_colour == $past(q.mode[OM_SYNC_BIT]))
    else $error("sync on colour wrong");
  slave_vsync_a: assert property (
    slave_sync && ce && !tc_fire |=> q.cyc == 12'h000 && q.line == 10'h000)
    else $error("slave vsync edge did not rephase counters");
  long_vsync_a: assert property (
    $rose(vsync_out_b) && vs_clean |-> vs_cnt == vs_exp)
    else $error("master vsync length wrong");
  pedestal_pal_a: assert property (
    ce && pal_select |=> !pedestal_enable)
    else $error("pedestal enabled in PAL");
  blank_filter_a: assert property (
    blank_filter_active |-> !blank_out_b && $past(q.mode[OM_FILT_BIT]))
    else $error("blank filter active outside blanking");
  sleep_enter_a: assert property (
    sleep_wr_s(1'b1) |=> sleep_active)
    else $error("sleep not entered");
  sleep_freeze_a: assert property (
    ce && q.mode[OM_SLEEP_BIT] && !tc_fire && !slave_sync |=>
      $stable(q.cyc) && $stable(q.line))
    else $error("counters moved in sleep");
  sleep_exit_a: assert property (
    sleep_wr_s(1'b0) |=> !sleep_active)
    else $error("sleep not left");
  reset_wake_a: assert property (
    $rose(rst_b) |-> !sleep_active && !q.mode[OM_SLEEP_BIT])
    else $error("sleep survived reset");
  master_sel_a: assert property (
    ce && !q.tim[ST_MST_BIT] |=> vsync_out_b && !timing_master)
    else $error("slave drives vsync");
  luma_delay_a: assert property (
    ce |=> luma_delay_cycles ==
      {2'b00, $past(q.tim[ST_LUMA_LSB+:2])} * LUMA_STEP_CYC)
    else $error("luma delay wrong");
  tc_fire_a: assert property (
    tc_fire && ce |=> timing_counter_reset && q.cyc == 12'h000 ##1
      !timing_counter_reset || !ce)
    else $error("counter reset toggle not honoured");
  tc_idle_a: assert property (
    !q.armed |=> !timing_counter_reset)
    else $error("counter reset without toggle");
  reg_hold_a: assert property (
    !om_wr && !st_wr |=> $stable(q.mode) && $stable(q.tim))
    else $error("register changed without write");
  tmode_mirror_a: assert property (
    ce |=> timing_mode_field == $past(q.tim[ST_TMODE_LSB+:2]))
    else $error("timing mode field wrong");
  master_mirror_a: assert property (
    ce |=> timing_master == $past(q.tim[ST_MST_BIT]))
    else $error("master select wrong");
  blank_use_a: assert property (
    ce |=> blank_input_used == $past(q.tim[ST_BLANK_BIT] && !q.tim[ST_MST_BIT]))
    else $error("blank input use wrong");
  blank_honour_a: assert property (
    ce && q.tim[ST_BLANK_BIT] && !q.tim[ST_MST_BIT] && !q.bl_f |=> !blank_out_b)
    else $error("external blank ignored in slave mode");
  pedestal_ntsc_a: assert property (
    ce && !pal_select |=> pedestal_enable == $past(q.mode[OM_SETUP_BIT]))
    else $error("NTSC pedestal wrong");
  composite_only_a: assert property (
    ce && !q.mode[OM_FMT_BIT] |=> !component_ypbpr && !sync_on_colour)
    else $error("component outputs active in composite format");
  sleep_vsync_a: assert property (
    ce && q.mode[OM_SLEEP_BIT] |=> vsync_out_b)
    else $error("vsync driven in sleep");
  sleep_port_a: assert property (
    st_wr && ce && q.mode[OM_SLEEP_BIT] |=> q.tim == $past(rif.wdata))
    else $error("register write lost in sleep");
  mode_write_a: assert property (
    om_wr && ce |=> q.mode == $past(rif.wdata))
    else $error("mode register write lost");
endmodule

/* File: testbench/vemtc_host_model.sv */
// Behavioural host master of the two-wire register port.
// Assumes a pull-up on the data line; scl is driven push-pull by the host.
`timescale 1ns/1ps
module vemtc_host_model (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  import vemtc_pkg::*;
  // Phase length in mclk; 2 is the least the port accepts
  int unsigned ph = 10;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (ph) @(posedge mclk);
  endtask
  // Data moves a full phase after scl falls, clear of the pin sync lag
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
    half();
  endtask
  task automatic start_c();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop_c();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = ~r;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    if (a == OUT_MODE_ADDR) d[7] = 1'b0;
    if (a == SYNC_TIM_ADDR) d[6] = 1'b0;
    start_c();
    byte_io({PORT_DEV_ADDR, 1'b0}, 1'b1, q, k[0]);
    byte_io(a, 1'b1, q, k[1]);
    byte_io(d, 1'b1, q, k[2]);
    stop_c();
    ok = &k;
  endtask
  // Single-byte read ended by a NACK, after a repeated start
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    start_c();
    byte_io({PORT_DEV_ADDR, 1'b0}, 1'b1, q, k[0]);
    byte_io(a, 1'b1, q, k[1]);
    start_c();
    byte_io({PORT_DEV_ADDR, 1'b1}, 1'b1, q, k[2]);
    byte_io(8'hff, 1'b1, d, q[0]);
    stop_c();
    ok = &k;
  endtask
endmodule

/* File: testbench/vemtc_top_tb.sv */
// Self-checking bench of the mode and sync timing control block.
// Assumes the host model as serial master and a pull-up on the data line.
`timescale 1ns/1ps
module vemtc_top_tb;
  import vemtc_pkg::*;
  logic        mclk, rst_b, ce, pal_select, vsync_in_b, blank_in_b;
  logic        sda_drive, sda_oe, scl, host_low, sda_line;
  logic        composite_video, component_ypbpr, sync_on_colour, pedestal_enable;
  logic        blank_filter_active, sleep_active, timing_master, blank_input_used;
  logic        pixel_port_format_bit, timing_counter_reset, vsync_out_b, blank_out_b;
  logic [1:0]  timing_mode_field;
  vemtc_luma_t luma_delay_cycles;
  logic        vs_filt;
  int          num_errors, total_checks;
  int          tcr_count = 0;
  int          vs_run = 0;
  int          vs_last = 0;
  // {pal, mode register} per case and the expected output flags
  localparam logic [5:0][8:0] MODE_STIM = {9'h000, 9'h003, 9'h005, 9'h011, 9'h110, 9'h006};
  localparam logic [5:0][3:0] MODE_EXP  = {4'h8, 4'h4, 4'h2, 4'h1, 4'h8, 4'h8};
  localparam logic [2:0][8:0] VS_CFG    = {9'h000, 9'h108, 9'h028};
  // Open-drain data line: low while either party pulls it
  assign sda_line = ~((sda_oe & ~sda_drive) | host_low);
  vemtc_top dut (.mclk, .rst_b, .ce, .scl, .sda(sda_line), .sda_drive, .sda_oe,
    .pal_select, .vsync_in_b, .blank_in_b, .composite_video, .component_ypbpr,
    .sync_on_colour, .pedestal_enable, .blank_filter_active, .sleep_active,
    .timing_master, .timing_mode_field, .blank_input_used, .luma_delay_cycles,
    .pixel_port_format_bit, .timing_counter_reset, .vsync_out_b, .blank_out_b);
  vemtc_host_model host (.mclk, .sda_line, .scl, .sda_low(host_low));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Pulse counter and vsync run length, sampled before each edge lands
  always @(posedge mclk) begin
    if (timing_counter_reset === 1'b1) tcr_count <= tcr_count + 1;
    if (vsync_out_b === 1'b0) begin
      if (vs_run == 0) vs_filt <= blank_filter_active;
      vs_run <= vs_run + 1;
    end else if (vs_run != 0) begin
      vs_last <= vs_run;
      vs_run <= 0;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.reg_write(a, d, ok);
    chk("write ack", 32'(ok), 32'h1);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       ok;
    host.reg_read(a, q, ok);
    chk("read ack", 32'(ok), 32'h1);
    chk(name, 32'(q), 32'(e));
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask
  task automatic t_reset();
    chk("composite", 32'(composite_video), 32'h1);
    chk("vsync out", 32'(vsync_out_b), 32'h1);
    chk("sda oe", 32'(sda_oe), 32'h0);
    rd("mode reset", OUT_MODE_ADDR, OUT_MODE_RST);
    rd("timing reset", SYNC_TIM_ADDR, SYNC_TIM_RST);
    wr(8'h05, 8'h5a);
    rd("unmapped", 8'h05, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_modes();
    for (int i = 0; i < 6; i++) begin
      pal_select <= MODE_STIM[i][8];
      wr(OUT_MODE_ADDR, MODE_STIM[i][7:0]);
      chk("out mode", 32'({composite_video, component_ypbpr, sync_on_colour,
        pedestal_enable}), 32'(MODE_EXP[i]));
      rd("mode back", OUT_MODE_ADDR, MODE_STIM[i][7:0]);
    end
    pal_select <= 1'b0;
    $display("test modes done");
  endtask
  task automatic t_timing();
    for (int i = 0; i < 4; i++) begin
      wr(SYNC_TIM_ADDR, {2'b00, 2'(i), 1'b1, 2'(i), 1'b0});
      chk("tmode", 32'(timing_mode_field), 32'(i));
      chk("luma", 32'(luma_delay_cycles), 32'(i * ((74 + 24) / 25)));
      chk("blank used", 32'(blank_input_used), 32'h1);
      chk("slave", 32'(timing_master), 32'h0);
    end
    // A slow host must be served the same
    host.ph = 25;
    wr(SYNC_TIM_ADDR, 8'h49);
    host.ph = 10;
    chk("master", 32'(timing_master), 32'h1);
    chk("blank unused", 32'(blank_input_used), 32'h0);
    chk("pixel bit", 32'(pixel_port_format_bit), 32'h0);
    rd("timing back", SYNC_TIM_ADDR, 8'h09);
    $display("test timing done");
  endtask
  task automatic t_vsync();
    int n;
    int k;
    int e;
    for (int i = 0; i < 3; i++) begin
      pal_select <= VS_CFG[i][8];
      wr(OUT_MODE_ADDR, VS_CFG[i][7:0]);
      e = VS_CFG[i][8] ? int'(PAL_HALF_CYC) : int'(NTSC_HALF_CYC);
      e = e * (VS_CFG[i][3] ? (VS_CFG[i][8] ? 5 : 6) : 2);
      n = tcr_count;
      wr(SYNC_TIM_ADDR, 8'h81);
      chk("early pulse", 32'(tcr_count), 32'(n));
      vs_last = 0;
      wr(SYNC_TIM_ADDR, 8'h01);
      chk("count reset", 32'(tcr_count), 32'(n + 1));
      k = 0;
      while (vs_last == 0 && k < 9000) begin
        @(posedge mclk);
        k++;
      end
      chk("vsync width", 32'(vs_last), 32'(e));
      chk("blank filter", 32'(vs_filt), 32'(VS_CFG[i][5]));
    end
    $display("test vsync done");
  endtask
  task automatic t_slave();
    wr(SYNC_TIM_ADDR, 8'h08);
    pal_select <= 1'b1;
    vsync_in_b <= 1'b0;
    blank_in_b <= 1'b0;
    repeat (5 * int'(PAL_HALF_CYC)) @(posedge mclk);
    chk("slave blank", 32'(blank_out_b), 32'h0);
    chk("slave vsync", 32'(vs_run), 32'h0);
    vsync_in_b <= 1'b1;
    blank_in_b <= 1'b1;
    repeat (8) @(posedge mclk);
    // A second fall rephases, so the master switch lands inside vsync
    vsync_in_b <= 1'b0;
    wr(SYNC_TIM_ADDR, 8'h01);
    chk("slave rephase", 32'(vsync_out_b), 32'h0);
    repeat (2 * int'(PAL_HALF_CYC)) @(posedge mclk);
    vsync_in_b <= 1'b1;
    pal_select <= 1'b0;
    $display("test slave done");
  endtask
  task automatic t_sleep();
    wr(OUT_MODE_ADDR, 8'h40);
    chk("sleep", 32'(sleep_active), 32'h1);
    wr(SYNC_TIM_ADDR, 8'h35);
    chk("sleep vsync", 32'(vsync_out_b), 32'h1);
    rd("sleep back", SYNC_TIM_ADDR, 8'h35);
    wr(OUT_MODE_ADDR, 8'h00);
    chk("wake", 32'(sleep_active), 32'h0);
    wr(OUT_MODE_ADDR, 8'h40);
    do_reset();
    chk("reset wake", 32'(sleep_active), 32'h0);
    rd("reset clears", SYNC_TIM_ADDR, 8'h00);
    $display("test sleep done");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    pal_select = 1'b0;
    vsync_in_b = 1'b1;
    blank_in_b = 1'b1;
    num_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
    t_reset();
    t_modes();
    t_timing();
    t_vsync();
    t_slave();
    t_sleep();
    give_verdict();
  end
  // Tests need some 65k cycles; a hang runs into this limit
  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
endmodule
